/* core/txcdc_core.sv */
`default_nettype none
module txcdc_core (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic desc_valid_in,
	input wire logic [7:0] context_command_field_in,
	input wire logic [3:0] descriptor_type_code_in,
	input wire logic [15:0] tx_interrupt_delay_in,
	input wire logic legacy_ip_mode_in,
	output logic desc_ready_out,
	output logic seg_ctx_load_out,
	output logic csum_ctx_load_out,
	output txcdc_pkg::txcdc_opts_s seg_opts_out,
	output logic ip_header_update_out,
	output txcdc_pkg::txcdc_wb_s writeback_out,
	output logic tx_interrupt_out,
	output logic delay_running_out,
	output logic bad_desc_out
);
	txcdc_pkg::txcdc_state_e state_r;
	txcdc_pkg::txcdc_state_e state_nxt;
	logic [7:0] cmd_r;
	logic tick;
	logic expire;
	logic running;

	// field decode of the latched command byte
	wire logic cmd_ide = cmd_r[txcdc_pkg::CMD_IDE_BIT];
	wire logic cmd_rs = cmd_r[txcdc_pkg::CMD_RS_BIT];
	wire logic cmd_seg = cmd_r[txcdc_pkg::CMD_SEG_BIT];
	wire logic cmd_ip = cmd_r[txcdc_pkg::CMD_IP_BIT];
	wire logic cmd_tcp = cmd_r[txcdc_pkg::CMD_TCP_BIT];
	wire logic cmd_descriptor_extension = cmd_r[txcdc_pkg::CMD_DESCRIPTOR_EXTENSION_BIT];
	wire logic in_decode = (state_r == txcdc_pkg::TXCDC_DECODE);
	wire logic in_wb = (state_r == txcdc_pkg::TXCDC_WRITEBACK);
	wire logic take = desc_ready_out && desc_valid_in;

	// malformed descriptors are flagged but still processed, software owns these bits
	wire logic rsv_set = context_command_field_in[txcdc_pkg::CMD_RSV6_BIT]
		| context_command_field_in[txcdc_pkg::CMD_RSV4_BIT];
	wire logic bad_now = take && (rsv_set
		|| !context_command_field_in[txcdc_pkg::CMD_DESCRIPTOR_EXTENSION_BIT]
		|| (descriptor_type_code_in != txcdc_pkg::DESCRIPTOR_TYPE_CODE_CONTEXT));

	// options only meaningful while segmenting; masked otherwise
	wire logic opt_tcp = cmd_seg & cmd_tcp;
	wire logic opt_ip = cmd_seg & cmd_ip;
	wire logic opt_generic = cmd_seg & ~cmd_tcp & ~cmd_ip;
	wire logic opt_ip_update = cmd_seg & legacy_ip_mode_in & cmd_ip;

	// timer control at write-back, regardless of segmentation bit
	wire logic wb_fire = in_wb && cmd_rs;
	wire logic delay_load = in_wb && cmd_ide;
	wire logic delay_clear = wb_fire && !cmd_ide;
	wire logic irq_now = delay_clear || expire;

	// status carries only descriptor done, reserved bits zero
	wire logic [3:0] wb_status = txcdc_pkg::STA_DONE;

	// one descriptor at a time: take, decode, write back
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			txcdc_pkg::TXCDC_IDLE: begin
				if (take)
					state_nxt = txcdc_pkg::TXCDC_DECODE;
			end
			txcdc_pkg::TXCDC_DECODE: begin
				state_nxt = txcdc_pkg::TXCDC_WRITEBACK;
			end
			txcdc_pkg::TXCDC_WRITEBACK: begin
				state_nxt = txcdc_pkg::TXCDC_IDLE;
			end
			default: begin
				state_nxt = txcdc_pkg::TXCDC_IDLE;
			end
		endcase
	end

	// state and command latch
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= txcdc_pkg::TXCDC_IDLE;
			cmd_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			if (take)
				cmd_r <= context_command_field_in;
		end
	end

	// context load strobes and options registered for the datapath
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			seg_ctx_load_out <= 1'b0;
			csum_ctx_load_out <= 1'b0;
			seg_opts_out <= '0;
			ip_header_update_out <= 1'b0;
		end else begin
			seg_ctx_load_out <= in_decode && cmd_seg;
			csum_ctx_load_out <= in_decode && !cmd_seg;
			if (in_decode && cmd_seg) begin
				seg_opts_out <= '{tcp: opt_tcp, ipv4: opt_ip, generic_block: opt_generic};
				ip_header_update_out <= opt_ip_update;
			end
		end
	end

	// handshake, write-back and interrupt outputs
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			desc_ready_out <= 1'b0;
			writeback_out <= '0;
			tx_interrupt_out <= 1'b0;
			delay_running_out <= 1'b0;
			bad_desc_out <= 1'b0;
		end else begin
			desc_ready_out <= (state_nxt == txcdc_pkg::TXCDC_IDLE);
			writeback_out.write <= wb_fire;
			writeback_out.status_nibble <= wb_fire ? wb_status : txcdc_pkg::STA_RESET;
			tx_interrupt_out <= irq_now;
			delay_running_out <= running;
			bad_desc_out <= bad_now;
		end
	end

	// descriptor extension is latched but drives nothing beyond the check
	wire logic unused_descriptor_extension = cmd_descriptor_extension;

	txcdc_tick u_tick (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.tick_out(tick)
	);

	txcdc_delay u_delay (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.tick_in(tick),
		.load_in(delay_load && cmd_rs),
		.clear_in(delay_clear),
		.delay_value_in(tx_interrupt_delay_in),
		.expire_out(expire),
		.running_out(running)
	);
endmodule // txcdc_core
`default_nettype wire

/* inc/txcdc_pkg.sv */
`default_nettype none
package txcdc_pkg;
	// command byte bit positions
	localparam int CMD_TCP_BIT = 0;
	localparam int CMD_IP_BIT = 1;
	localparam int CMD_SEG_BIT = 2;
	localparam int CMD_RS_BIT = 3;
	localparam int CMD_RSV4_BIT = 4;
	localparam int CMD_DESCRIPTOR_EXTENSION_BIT = 5;
	localparam int CMD_RSV6_BIT = 6;
	localparam int CMD_IDE_BIT = 7;
	// status nibble
	localparam int STA_DD_BIT = 0;
	localparam logic [3:0] STA_RESET = 4'h0;
	localparam logic [3:0] STA_DONE = 4'h1;
	localparam logic [3:0] DESCRIPTOR_TYPE_CODE_CONTEXT = 4'h0;
	localparam int DELAY_W = 16;
	localparam logic [15:0] DELAY_ZERO = 16'h0000;
	localparam logic [15:0] DELAY_ONE = 16'h0001;
	localparam int TICK_NS = 1024;
	localparam int CLK_NS = 5;
	localparam int TICK_CYCLES = TICK_NS / CLK_NS;
	localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);
	localparam logic [7:0] TICK_ZERO = 8'h00;

	// decoded packet-type options of one context
	typedef struct packed {
		logic tcp;
		logic ipv4;
		logic generic_block;
	} txcdc_opts_s;

	// write-back record handed to the fetch engine
	typedef struct packed {
		logic [3:0] status_nibble;
		logic write;
	} txcdc_wb_s;

	typedef enum logic [1:0] {
		TXCDC_IDLE = 2'b00,
		TXCDC_DECODE = 2'b01,
		TXCDC_WRITEBACK = 2'b11
	} txcdc_state_e;
endpackage : txcdc_pkg
`default_nettype wire

/* core/txcdc_tick.sv */
`default_nettype none
// one-cycle enable every delay tick
module txcdc_tick (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	output logic tick_out
);
	logic [7:0] cnt_r;
	wire logic at_end = (cnt_r == txcdc_pkg::TICK_LAST);

	// free-running divider; tick granularity bounds delay accuracy to one tick
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_r <= txcdc_pkg::TICK_ZERO;
			tick_out <= 1'b0;
		end else begin
			cnt_r <= at_end ? txcdc_pkg::TICK_ZERO : cnt_r + 8'h01;
			tick_out <= at_end;
		end
	end
endmodule // txcdc_tick
`default_nettype wire

/* core/txcdc_delay.sv */
`default_nettype none
// transmit interrupt delay countdown
module txcdc_delay (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic tick_in,
	input wire logic load_in,
	input wire logic clear_in,
	input wire logic [15:0] delay_value_in,
	output logic expire_out,
	output logic running_out
);
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	wire logic hit_one = running_out && tick_in && (count_r == txcdc_pkg::DELAY_ONE);

	// load beats a running count, clear stops it
	always_comb begin
		count_nxt = count_r;
		if (load_in)
			count_nxt = delay_value_in;
		else if (clear_in)
			count_nxt = txcdc_pkg::DELAY_ZERO;
		else if (running_out && tick_in)
			count_nxt = count_r - txcdc_pkg::DELAY_ONE;
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_r <= txcdc_pkg::DELAY_ZERO;
			expire_out <= 1'b0;
		end else begin
			count_r <= count_nxt;
			expire_out <= hit_one && !load_in && !clear_in;
		end
	end

	assign running_out = (count_r != txcdc_pkg::DELAY_ZERO);
endmodule // txcdc_delay
`default_nettype wire

/* bench/txcdc_properties.sv */
`default_nettype none
// port relations of the command decoder
module txcdc_properties (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic desc_valid_in,
	input wire logic [7:0] context_command_field_in,
	input wire logic [15:0] tx_interrupt_delay_in,
	input wire logic desc_ready_out,
	input wire logic seg_ctx_load_out,
	input wire logic csum_ctx_load_out,
	input wire txcdc_pkg::txcdc_opts_s seg_opts_out,
	input wire txcdc_pkg::txcdc_wb_s writeback_out,
	input wire logic tx_interrupt_out,
	input wire logic delay_running_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// take strobe and byte alias
	wire logic tk = desc_ready_out & desc_valid_in;
	wire logic [7:0] c = context_command_field_in;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	a_take_blocks: assert property (tk |=> !desc_ready_out [*2]) else $error("offer open too soon");
	a_ctx_select: assert property (tk |-> ##2 seg_ctx_load_out == $past(c[2], 2)
		&& csum_ctx_load_out != $past(c[2], 2)) else $error("wrong context loaded");
	a_opts_type: assert property (tk && c[2] |-> ##2 seg_opts_out.tcp == $past(c[0], 2)
		&& seg_opts_out.ipv4 == $past(c[1], 2)) else $error("packet type wrong");
	a_generic_blk: assert property (seg_ctx_load_out |-> seg_opts_out.generic_block
		== !(seg_opts_out.tcp | seg_opts_out.ipv4)) else $error("generic flag wrong");
	a_csum_keeps: assert property (csum_ctx_load_out |-> $stable(seg_opts_out)) else $error("opts moved");
	a_status_wb: assert property (tk |-> ##3 writeback_out.write == $past(c[3], 3)
		&& writeback_out.status_nibble == {3'h0, $past(c[3], 3)}) else $error("write-back wrong");
	a_irq_now: assert property (tk && c[3] && !c[7] |-> ##3 tx_interrupt_out) else $error("no irq");
	a_delay_load: assert property (tk && c[3] && c[7] && tx_interrupt_delay_in != 16'h0000
		|-> ##[3:5] delay_running_out) else $error("countdown idle");
endmodule // txcdc_properties
`default_nettype wire

/* bench/txcdc_host.sv */
`default_nettype none
// software side: offers one command byte at a time
module txcdc_host (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic go_in,
	input wire logic bad_in,
	input wire logic [7:0] cmd_in,
	input wire logic ready_in,
	output logic valid_out,
	output logic [7:0] cmd_out,
	output logic [3:0] type_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// offer held until ready seen; released byte is scrambled, not kept
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			valid_out <= 1'b0;
			cmd_out <= 8'h00;
			type_out <= 4'h0;
		end else if (valid_out & ready_in) begin
			valid_out <= 1'b0;
			cmd_out <= ~cmd_out;
		end else if (go_in & !valid_out) begin
			valid_out <= 1'b1;
			cmd_out <= (cmd_in & 8'haf) | 8'h20 | {1'b0, bad_in, 6'h00};
			type_out <= 4'h0;
		end
	end
endmodule // txcdc_host
`default_nettype wire

/* bench/txcdc_core_bench.sv */
`default_nettype none
module txcdc_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, go = 0, bad = 0, legacy = 0, tk = 0;
	logic valid, ready, segl, csl, iph, irq, run, bd;
	logic [7:0] cin = 8'h00, cmd;
	logic [15:0] dly = 16'h0000;
	logic [3:0] typ;
	txcdc_pkg::txcdc_opts_s opts;
	txcdc_pkg::txcdc_wb_s wb;
	int errors = 0, n_tests = 0, n;
	// clock and take marker
	always #2.5 clk = ~clk;
	always @(posedge clk) tk <= valid & ready;
	txcdc_host HOST (.ref_clk_in(clk), .rst_n_in(rst_n), .go_in(go), .bad_in(bad), .cmd_in(cin),
		.ready_in(ready), .valid_out(valid), .cmd_out(cmd), .type_out(typ));
	txcdc_core DUT (.ref_clk_in(clk), .rst_n_in(rst_n), .desc_valid_in(valid), .context_command_field_in(cmd),
		.descriptor_type_code_in(typ), .tx_interrupt_delay_in(dly), .legacy_ip_mode_in(legacy),
		.desc_ready_out(ready), .seg_ctx_load_out(segl), .csum_ctx_load_out(csl), .seg_opts_out(opts),
		.ip_header_update_out(iph), .writeback_out(wb), .tx_interrupt_out(irq),
		.delay_running_out(run), .bad_desc_out(bd));
	task chk(string nm, logic [7:0] e, logic [7:0] s);
		n_tests++;
		if (e !== s) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// one descriptor, model of the byte compared in cycles 1 to 3
	task send(logic [7:0] c, logic b);
		logic [7:0] k;
		k = (c & 8'haf) | 8'h20 | {1'b0, b, 6'h00};
		@(posedge clk);
		go <= 1'b1;
		cin <= c;
		bad <= b;
		@(posedge clk);
		go <= 1'b0;
		#1;
		for (int w = 0; w < 20 && !tk; w++) begin
			@(posedge clk);
			#1;
		end
		// a descriptor that is never taken counts as a mismatch
		if (!tk) chk("take", 8'h01, 8'h00);
		chk("bad", 8'(b), 8'(bd));
		@(posedge clk);
		#1;
		chk("seg", {6'h0, k[2], !k[2]}, {6'h0, segl, csl});
		if (k[2]) chk("opts", {5'h0, k[0], k[1], !k[0] & !k[1]}, 8'(opts));
		if (k[2]) chk("iph", 8'(legacy & k[1]), 8'(iph));
		@(posedge clk);
		#1;
		chk("wb", {3'h0, 4'(k[3]), k[3]}, 8'(wb));
		chk("irq", 8'(k[3] & !k[7]), 8'(irq));
	endtask
	// cycles until the next interrupt pulse, hi + 1 when none
	task gap(int hi);
		n = 0;
		while (irq !== 1'b1 && n <= hi) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	initial begin
		void'($urandom(56355));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 40; i++) begin
			@(posedge clk);
			legacy <= 1'(i);
			send(8'($urandom), 1'($urandom % 4 == 0));
		end
		// delay inputs move on a rising edge, never between edges
		@(posedge clk);
		dly <= 16'h0002;
		send(8'h8c, 1'b0);
		gap(420);
		chk("delay", 8'(n >= 200 && n <= 415), 8'h01);
		@(posedge clk);
		dly <= 16'h0004;
		send(8'h88, 1'b0);
		repeat (300) @(posedge clk);
		send(8'h88, 1'b0);
		gap(830);
		chk("reload", 8'(n >= 600 && n <= 825), 8'h01);
		send(8'h88, 1'b0);
		send(8'h08, 1'b0);
		// step past the immediate pulse before timing the cleared countdown
		@(posedge clk);
		#1;
		gap(900);
		chk("cleared", 8'(n > 900), 8'h01);
		give_verdict;
	end
	// hang guard
	initial begin
		#200000;
		errors++;
		give_verdict;
	end
endmodule // txcdc_core_bench
bind txcdc_core txcdc_properties CHK (
	.ref_clk_in(ref_clk_in),
	.rst_n_in(rst_n_in),
	.desc_valid_in(desc_valid_in),
	.context_command_field_in(context_command_field_in),
	.tx_interrupt_delay_in(tx_interrupt_delay_in),
	.desc_ready_out(desc_ready_out),
	.seg_ctx_load_out(seg_ctx_load_out),
	.csum_ctx_load_out(csum_ctx_load_out),
	.seg_opts_out(seg_opts_out),
	.writeback_out(writeback_out),
	.tx_interrupt_out(tx_interrupt_out),
	.delay_running_out(delay_running_out)
);
`default_nettype wire
